/* include/odac_regs.vh */
// Constants for the octal converter serial load logic
// Function
// - Sample data on serial clock falling edges
// - Frame sync low enables shifting
// - Matching word loads latch on sixteenth edge
// - Twelve data, address, three select bits
// - Address mismatch discards the word
// - Serial output passes all words
// - Shift register output drives serial out
// - Update low copies input to output latches
// - Clear low forces output latches to zero
// - Select bits decode binary channel number
// - Stop shifting after sixteen bits until resync
// - Serial out changes on following rising edge
// - Clear leaves input latches untouched
`ifndef ODAC_REGS_VH
`define ODAC_REGS_VH
`define ODAC_WORD_BITS 16
`define ODAC_DATA_BITS 12
`define ODAC_DATA_MSB 15
`define ODAC_DATA_LSB 4
`define ODAC_ADDR_BIT 3
`define ODAC_SEL_MSB 2
`define ODAC_SEL_LSB 0
`define ODAC_CHANNELS 8
`define ODAC_CNT_LAST 5'h10
`define ODAC_DATA_RESET 12'h000
`endif

/* rtl/odac_latch_mem.v */
// Eight-word latch bank with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "odac_regs.vh"
module odac_latch_mem #(
	parameter WIDTH = `ODAC_DATA_BITS,
	parameter DEPTH = `ODAC_CHANNELS,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// Read port
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	integer i;

	// Write and registered read; reset clears contents
	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
			rd_data <= {WIDTH{1'b0}};
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // odac_latch_mem
`default_nettype wire

/* rtl/odac_serial_load.v */
// Serial loading logic of the octal converter: shifter, input latches, output latches
`timescale 1ns/1ps
`default_nettype none
`include "odac_regs.vh"
module odac_serial_load #(
	parameter DW = `ODAC_DATA_BITS,
	parameter NCH = `ODAC_CHANNELS
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Serial link pins
	input wire frame_sync_n,
	input wire serial_clock_in,
	input wire serial_data_in,
	output reg serial_data_out,
	// Control pins
	input wire device_address_pin,
	input wire latch_update_n,
	input wire output_zero_n,
	// Output latch values, channel 0 in low bits
	output reg [NCH*DW-1:0] dac_codes,
	// Pulse when a matching word is written
	output reg load_done
);
	// Two-flop synchronisers, one pair per pin
	reg [1:0] fs_sync_reg;
	reg [1:0] ck_sync_reg;
	reg [1:0] di_sync_reg;
	reg [1:0] ad_sync_reg;
	reg [1:0] up_sync_reg;
	reg [1:0] zr_sync_reg;
	// Previous synchronised levels for edge detection
	reg ck_prev_reg;
	reg fs_prev_reg;
	// Synchronised pin levels and detected edges
	wire fs_n;
	wire ck;
	wire di;
	wire addr_pin;
	wire upd_n;
	wire zero_n;
	wire ck_fall;
	wire ck_rise;
	wire fs_fall;
	wire take_bit; // A bit is shifted in this cycle
	// Frame state
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [4:0] cnt_reg;
	reg [15:0] shift_reg;
	reg [15:0] word;
	// Latch bank access
	reg wr_en_reg;
	reg [2:0] wr_addr_reg;
	reg [DW-1:0] wr_data_reg;
	reg [2:0] scan_reg;
	reg [2:0] scan_d_reg;
	reg stale_reg; // Last read raced a write to the same word
	wire [DW-1:0] rd_data;
	reg [DW-1:0] in_copy [0:NCH-1];
	integer k;
	integer j;

	// Word fields
	function addr_ok;
		input [15:0] w;
		input a;
		begin
			addr_ok = (w[`ODAC_ADDR_BIT] == a);
		end
	endfunction

	// Count value while the sixteenth bit is taken
	function last_bit;
		input [4:0] c;
		begin
			last_bit = (c == `ODAC_CNT_LAST - 5'h1);
		end
	endfunction

	// Two-flop pin synchronisers
	always @(posedge clk) begin
		if (rst) begin
			fs_sync_reg <= 2'h3;
			ck_sync_reg <= 2'h0;
			di_sync_reg <= 2'h0;
			ad_sync_reg <= 2'h0;
			up_sync_reg <= 2'h3;
			zr_sync_reg <= 2'h3;
			ck_prev_reg <= 1'b0;
			fs_prev_reg <= 1'b1;
		end else begin
			fs_sync_reg <= {fs_sync_reg[0], frame_sync_n};
			ck_sync_reg <= {ck_sync_reg[0], serial_clock_in};
			di_sync_reg <= {di_sync_reg[0], serial_data_in};
			ad_sync_reg <= {ad_sync_reg[0], device_address_pin};
			up_sync_reg <= {up_sync_reg[0], latch_update_n};
			zr_sync_reg <= {zr_sync_reg[0], output_zero_n};
			ck_prev_reg <= ck_sync_reg[1];
			fs_prev_reg <= fs_sync_reg[1];
		end
	end
	assign fs_n = fs_sync_reg[1];
	assign ck = ck_sync_reg[1];
	assign di = di_sync_reg[1];
	assign addr_pin = ad_sync_reg[1];
	assign upd_n = up_sync_reg[1];
	assign zero_n = zr_sync_reg[1];
	assign ck_fall = ck_prev_reg & ~ck;
	assign ck_rise = ~ck_prev_reg & ck;
	assign fs_fall = fs_prev_reg & ~fs_n;
	assign take_bit = (state_reg == ST_SHIFT) & ~fs_n & ck_fall;

	// Incoming word after this falling edge
	always @* begin
		word = {shift_reg[14:0], di};
	end

	// Frame state selection
	always @* begin
		case (state_reg)
			ST_IDLE: state_next = (fs_fall | ~fs_n) ? ST_SHIFT : ST_IDLE;
			ST_SHIFT: begin
				if (fs_n) state_next = ST_IDLE;
				else if (ck_fall && last_bit(cnt_reg)) state_next = ST_DONE;
				else state_next = ST_SHIFT;
			end
			ST_DONE: state_next = fs_fall ? ST_SHIFT : (fs_n ? ST_IDLE : ST_DONE);
			default: state_next = ST_IDLE;
		endcase
	end

	// Frame state and bit counter; counter clears outside the shift state
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg != ST_SHIFT) begin
				cnt_reg <= 5'h00;
			end else if (take_bit) begin
				cnt_reg <= cnt_reg + 5'h01;
			end
		end
	end

	// Input shift register, bit 15 arrives first
	always @(posedge clk) begin
		if (rst) begin
			shift_reg <= 16'h0000;
		end else if (take_bit) begin
			shift_reg <= word;
		end
	end

	// Latch write request on the sixteenth bit of a matching word
	always @(posedge clk) begin
		if (rst) begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 3'h0;
			wr_data_reg <= `ODAC_DATA_RESET;
			load_done <= 1'b0;
		end else begin
			wr_en_reg <= 1'b0;
			load_done <= 1'b0;
			if (take_bit && last_bit(cnt_reg) && addr_ok(word, addr_pin)) begin
				wr_en_reg <= 1'b1;
				wr_addr_reg <= word[`ODAC_SEL_MSB:`ODAC_SEL_LSB];
				wr_data_reg <= word[`ODAC_DATA_MSB:`ODAC_DATA_LSB];
				load_done <= 1'b1;
			end
		end
	end

	// Daisy-chain out; shifted bit leaves on next rising edge, match or not
	always @(posedge clk) begin
		if (rst) begin
			serial_data_out <= 1'b0;
		end else if (ck_rise) begin
			serial_data_out <= shift_reg[15];
		end
	end

	// Input latch bank
	odac_latch_mem #(.WIDTH(DW), .DEPTH(NCH), .AW(3)) u_mem (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_en_reg),
		.wr_addr(wr_addr_reg),
		.wr_data(wr_data_reg),
		.rd_addr(scan_reg),
		.rd_data(rd_data)
	);

	// Scan copy of all channels; a read racing a write is dropped
	always @(posedge clk) begin
		if (rst) begin
			scan_reg <= 3'h0;
			scan_d_reg <= 3'h0;
			stale_reg <= 1'b0;
			for (k = 0; k < NCH; k = k + 1) in_copy[k] <= `ODAC_DATA_RESET;
		end else begin
			scan_reg <= scan_reg + 3'h1;
			scan_d_reg <= scan_reg;
			stale_reg <= wr_en_reg & (scan_reg == wr_addr_reg);
			if (!stale_reg) in_copy[scan_d_reg] <= rd_data;
			if (wr_en_reg) in_copy[wr_addr_reg] <= wr_data_reg;
		end
	end

	// Output latches: clear wins, update copies all at once
	always @(posedge clk) begin
		if (rst) begin
			dac_codes <= {NCH*DW{1'b0}};
		end else begin
			for (j = 0; j < NCH; j = j + 1) begin
				if (!zero_n) dac_codes[j*DW +: DW] <= `ODAC_DATA_RESET;
				else if (!upd_n) dac_codes[j*DW +: DW] <= in_copy[j];
			end
		end
	end
endmodule // odac_serial_load
`default_nettype wire

/* test/odac_monitor.sv */
// Port checker for the serial load logic
`timescale 1ns/1ps
`default_nettype none
module odac_monitor (
	// Clock, reset and watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic frame_sync_n,
	input wire logic serial_clock_in,
	input wire logic serial_data_out,
	input wire logic latch_update_n,
	input wire logic output_zero_n,
	input wire logic [95:0] dac_codes,
	input wire logic load_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_CLR: assert property (!output_zero_n [*4] |-> dac_codes == 96'h0)
		else $error("clear ignored");
	AST_CLR_FALL: assert property ($fell(output_zero_n) |-> ##[1:4] dac_codes == 96'h0)
		else $error("clear slow");
	AST_GAP: assert property (load_done |=> !load_done [*8])
		else $error("done pulse");
	AST_DCK: assert property (load_done |-> !$past(serial_clock_in, 2))
		else $error("done timing");
	AST_DFS: assert property (load_done |-> !$past(frame_sync_n, 4))
		else $error("done outside frame");
	AST_SDO: assert property ($changed(serial_data_out) |-> $past(serial_clock_in, 2))
		else $error("out timing");
	AST_IDLE: assert property (!serial_clock_in [*5] |-> $stable(serial_data_out))
		else $error("out moved");
	AST_HLD: assert property ((latch_update_n && output_zero_n) [*8] |=> $stable(dac_codes))
		else $error("codes moved");
endmodule // odac_monitor
bind odac_serial_load odac_monitor mon (.clk(clk), .rst(rst), .frame_sync_n(frame_sync_n),
	.serial_clock_in(serial_clock_in), .serial_data_out(serial_data_out),
	.latch_update_n(latch_update_n), .output_zero_n(output_zero_n), .dac_codes(dac_codes),
	.load_done(load_done));
`default_nettype wire

/* test/odac_host_model.sv */
// Host that sends framed serial words
`timescale 1ns/1ps
`default_nettype none
module odac_host_model (
	// Clock and link pins
	input wire logic clk,
	output logic frame_sync_n = 1'b1,
	output logic serial_clock_in = 1'b0,
	output logic serial_data_in = 1'b0
);
	integer ph = 4; // Clocks per phase, 8 for a slow host
	// Wait n clocks, then the drive delay
	task automatic wt(input integer n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// Sixteen bits, bit 15 first, data moved after each rise
	task automatic send(input [15:0] w);
		integer i;
		frame_sync_n = 1'b0;
		for (i = 15; i >= 0; i = i - 1) begin
			wt(ph);
			serial_clock_in = 1'b1;
			wt(1);
			serial_data_in = w[i];
			wt(ph - 1);
			serial_clock_in = 1'b0;
		end
		wt(8);
		frame_sync_n = 1'b1;
		serial_data_in = ~serial_data_in; // Released line shows no stale bit
	endtask
endmodule // odac_host_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the serial load logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic device_address_pin = 1'b0;
	logic latch_update_n = 1'b1;
	logic output_zero_n = 1'b1;
	logic [31:0] lfsr = 32'hc200;
	logic [95:0] inl = 96'h0;
	logic [15:0] w;
	logic [15:0] sdo_word = 16'h0000, prev_w = 16'h0000;
	wire frame_sync_n, serial_clock_in, serial_data_in, serial_data_out, load_done;
	wire [95:0] dac_codes;
	integer failures = 0, compares = 0, ndone = 0, nexp = 0, i;
	// Clock and load pulse counter
	always #12.5 clk = ~clk;
	always @(posedge clk)
		if (load_done === 1'b1) ndone <= ndone + 1;
	odac_host_model host (.clk(clk), .frame_sync_n(frame_sync_n),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in));
	odac_serial_load uut (.clk(clk), .rst(rst), .frame_sync_n(frame_sync_n),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .device_address_pin(device_address_pin),
		.latch_update_n(latch_update_n), .output_zero_n(output_zero_n),
		.dac_codes(dac_codes), .load_done(load_done));
	// Chain output as the next device would take it
	always @(negedge serial_clock_in) sdo_word <= {sdo_word[14:0], serial_data_out};
	// Random source and expected latch contents
	function automatic [31:0] step(input [31:0] s);
		step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [95:0] put(input [95:0] c, input [15:0] v);
		put = c;
		put[v[2:0] * 12 +: 12] = v[15:4];
	endfunction
	task automatic chk(input [95:0] got, input [95:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000;
		failures = failures + 1;
		close_out;
	end
	// All channels, a foreign address, a slow host, then update and clear
	initial begin
		host.wt(2);
		rst = 1'b0;
		for (i = 0; i < 12; i = i + 1) begin
			lfsr = step(lfsr);
			device_address_pin = i[3];
			host.ph = (i == 10) ? 8 : 4;
			w = {(i == 0) ? 12'hfff : lfsr[11:0], i[3] ^ (i == 9), i[2:0]};
			host.send(w);
			host.wt(8);
			nexp = nexp + (w[3] == device_address_pin);
			inl = (w[3] == device_address_pin) ? put(inl, w) : inl;
			chk(ndone, nexp);
			chk(sdo_word, prev_w);
			prev_w = w;
		end
		chk(dac_codes, 96'h0);
		latch_update_n = 1'b0;
		host.wt(14);
		chk(dac_codes, inl);
		output_zero_n = 1'b0;
		host.wt(6);
		chk(dac_codes, 96'h0);
		output_zero_n = 1'b1;
		host.wt(14);
		chk(dac_codes, inl);
		lfsr = step(lfsr);
		w = {lfsr[11:0], 1'b1, 3'h5};
		host.send(w);
		host.wt(14);
		inl = put(inl, w);
		chk(dac_codes, inl);
		latch_update_n = 1'b1;
		close_out;
	end
endmodule // testbench
`default_nettype wire
